// ===== fpes_pkg.sv
// package: command codes, status bits, bus timing and apb map for the flash host controller
package fpes_pkg;
   // ==========================================
   // flash command codes
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
   localparam logic [7:0] CMD_PROG_ALT = 8'h10;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_ERASE_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_ERASE_RESUME = 8'hd0;
   // ==========================================
   // status bit positions
   localparam int SEQ_READY_POS = 7;
   localparam int SUSPENDED_POS = 6;
   localparam int ERASE_FAIL_POS = 5;
   localparam int PROGRAM_FAIL_POS = 4;
   localparam int SUPPLY_LOW_POS = 3;
   // ==========================================
   // pin timing: one access phase and the recovery gap between writes on the flash bus
   localparam int CLK_MHZ = 50;
   localparam int ACCESS_NS = 120;
   localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int RECOVER_NS = 40;
   localparam int RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;
   // ==========================================
   // apb register offsets
   localparam logic [7:0] REG_ADDR = 8'h00;
   localparam logic [7:0] REG_DATA = 8'h04;
   localparam logic [7:0] REG_CTRL = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0c;
   localparam logic [7:0] REG_RDATA = 8'h10;
   localparam logic [7:0] REG_FSTAT = 8'h14;
   // ==========================================
   // operation codes written to the control register
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_PROGRAM = 3'h1,
      OP_ERASE = 3'h2,
      OP_SUSPEND = 3'h3,
      OP_RESUME = 3'h4,
      OP_READ_ARRAY = 3'h5,
      OP_CLEAR = 3'h6,
      OP_POLL = 3'h7
   } fpes_op_type;
   // pins driven toward the flash
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [17:0] addr;
   } fpes_pins_type;
   localparam logic [17:0] ADDR_RST = 18'h00000;
   localparam logic [15:0] DATA_RST = 16'h0000;
endpackage : fpes_pkg

// ===== fpes_host.sv
// host controller: sequences flash commands and polls the status register
`timescale 1ns/1ps
// How it works
// - after clear, issue explicit read command
// - program is setup write then data write
// - after operation, read array before array data
// - erase is setup then confirm, block latched
// - supply low blocks erase until cleared
// - suspend halts erase; poll for effect
// - resume completes erase; then read, clear
// - erase setup 20h, confirm d0h, in-block address
// - write ffh after last erase
// - program setup is 40h or 10h
// - clear status is 50h
// - read status is 70h
module fpes_host
   import fpes_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic [17:0] flash_addr,
   output logic [15:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [15:0] flash_dq_in
);
   // ==========================================
   // state and storage
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WR1 = 3'b001,
      ST_GAP = 3'b011,
      ST_WR2 = 3'b010,
      ST_RD = 3'b110,
      ST_DONE = 3'b111
   } fpes_state_type;
   fpes_state_type state_ff, nxt_state; // sequencer state
   fpes_op_type op_ff, nxt_op; // operation in flight
   fpes_pins_type pins_ff, nxt_pins; // registered flash pins
   logic [15:0] dq_ff, nxt_dq; // write data on dq
   logic dq_oe_ff, nxt_dq_oe; // drive enable on dq
   logic [7:0] cnt_ff, nxt_cnt; // phase counter
   logic [17:0] addr_ff, nxt_addr; // target address
   logic [15:0] data_ff, nxt_data; // program data
   logic [15:0] rdata_ff, nxt_rdata; // last read word
   logic [7:0] fstat_ff, nxt_fstat; // last status byte seen
   logic busy_ff, nxt_busy; // sequence running
   logic [31:0] prdata_ff, nxt_prdata; // apb read data
   logic pready_ff, nxt_pready; // apb answer
   logic [15:0] dq_s1_ff, dq_s2_ff; // dq synchroniser
   logic [7:0] cmd1, cmd2; // command bytes for the op
   logic two_writes; // op needs second write
   logic wants_read; // op reads back after writes

   // ==========================================
   // command table: which bytes each op writes
   always_comb begin
      cmd1 = CMD_READ_STATUS;
      cmd2 = CMD_READ_STATUS;
      two_writes = 1'b0;
      wants_read = 1'b1;
      case (op_ff)
         OP_PROGRAM: begin
            cmd1 = CMD_PROG_SETUP;
            two_writes = 1'b1; // data write follows
         end
         OP_ERASE: begin
            cmd1 = CMD_ERASE_SETUP;
            cmd2 = CMD_ERASE_CONFIRM;
            two_writes = 1'b1;
         end
         OP_SUSPEND: cmd1 = CMD_ERASE_SUSPEND;
         OP_RESUME: cmd1 = CMD_ERASE_RESUME;
         OP_READ_ARRAY: cmd1 = CMD_READ_ARRAY;
         OP_CLEAR: begin
            cmd1 = CMD_CLEAR_STATUS; // only way past a supply-low refusal
            wants_read = 1'b0; // explicit read command needed later
         end
         default: cmd1 = CMD_READ_STATUS; // poll
      endcase
   end

   // ==========================================
   // sequencer and apb next state
   always_comb begin
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_pins = pins_ff;
      nxt_dq = dq_ff;
      nxt_dq_oe = dq_oe_ff;
      nxt_cnt = cnt_ff;
      nxt_addr = addr_ff;
      nxt_data = data_ff;
      nxt_rdata = rdata_ff;
      nxt_fstat = fstat_ff;
      nxt_busy = busy_ff;
      nxt_prdata = prdata_ff;
      nxt_pready = 1'b0;
      // apb slave: answers one cycle after the access phase starts
      if (psel && penable && !pready_ff) begin
         nxt_pready = 1'b1;
         nxt_prdata = 32'h00000000;
         if (pwrite) begin
            if (paddr == REG_ADDR) nxt_addr = pwdata[17:0];
            else if (paddr == REG_DATA) nxt_data = pwdata[15:0];
            else if (paddr == REG_CTRL && !busy_ff) begin
               nxt_op = fpes_op_type'(pwdata[2:0]); // ignored while busy
               nxt_busy = (pwdata[2:0] != 3'h0);
               nxt_state = (pwdata[2:0] != 3'h0) ? ST_WR1 : ST_IDLE;
               nxt_cnt = 8'h00;
            end
         end else begin
            case (paddr)
               REG_ADDR: nxt_prdata = {14'h0000, addr_ff};
               REG_DATA: nxt_prdata = {16'h0000, data_ff};
               REG_CTRL: nxt_prdata = {29'h00000000, op_ff};
               REG_STAT: nxt_prdata = {31'h00000000, busy_ff};
               REG_RDATA: nxt_prdata = {16'h0000, rdata_ff};
               REG_FSTAT: nxt_prdata = {24'h000000, fstat_ff};
               default: nxt_prdata = 32'h00000000;
            endcase
         end
      end
      case (state_ff)
         ST_WR1, ST_WR2: begin
            // write pulse: ce and we low, data driven, address within block
            nxt_pins.addr = addr_ff;
            nxt_pins.ce_n = 1'b0;
            nxt_pins.oe_n = 1'b1;
            nxt_dq_oe = 1'b1;
            nxt_dq = (state_ff == ST_WR2 && op_ff == OP_PROGRAM) ? data_ff :
                     {8'h00, (state_ff == ST_WR2) ? cmd2 : cmd1};
            nxt_pins.we_n = (cnt_ff >= 8'(ACCESS_CYC)); // low for the first ACCESS_CYC cycles
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_ff == 8'(ACCESS_CYC)) begin
               nxt_cnt = 8'h00;
               nxt_state = (state_ff == ST_WR1 && two_writes) ? ST_GAP :
                           (wants_read ? ST_RD : ST_DONE);
               nxt_pins.we_n = 1'b1;
            end
         end
         ST_GAP: begin
            // recovery with ce high between the two writes
            nxt_pins.ce_n = 1'b1;
            nxt_pins.we_n = 1'b1;
            nxt_dq_oe = 1'b0;
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_ff == 8'(RECOVER_CYC)) begin
               nxt_cnt = 8'h00;
               nxt_state = ST_WR2;
            end
         end
         ST_RD: begin
            // hold ce low and toggle oe low so status latches fresh
            nxt_dq_oe = 1'b0;
            nxt_pins.ce_n = 1'b0;
            nxt_pins.we_n = 1'b1;
            nxt_pins.oe_n = 1'b0;
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_ff == 8'(ACCESS_CYC) + 8'h02) begin
               nxt_rdata = dq_s2_ff; // sampled after two synchroniser stages
               if (op_ff != OP_READ_ARRAY) nxt_fstat = dq_s2_ff[7:0];
               nxt_cnt = 8'h00;
               nxt_state = ST_DONE;
            end
         end
         ST_DONE: begin
            // deselect: device releases dq, which then toggles; saves power
            nxt_pins.ce_n = 1'b1;
            nxt_pins.oe_n = 1'b1;
            nxt_busy = 1'b0;
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_pins.ce_n = 1'b1;
            nxt_pins.oe_n = 1'b1;
            nxt_pins.we_n = 1'b1;
            nxt_dq_oe = 1'b0;
         end
      endcase
   end

   // ==========================================
   // registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_IDLE;
         op_ff <= OP_NONE;
         pins_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: ADDR_RST};
         dq_ff <= DATA_RST;
         dq_oe_ff <= 1'b0;
         cnt_ff <= 8'h00;
         addr_ff <= ADDR_RST;
         data_ff <= DATA_RST;
         rdata_ff <= DATA_RST;
         fstat_ff <= 8'h00;
         busy_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
         pready_ff <= 1'b0;
         dq_s1_ff <= DATA_RST;
         dq_s2_ff <= DATA_RST;
      end else begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         pins_ff <= nxt_pins;
         dq_ff <= nxt_dq;
         dq_oe_ff <= nxt_dq_oe;
         cnt_ff <= nxt_cnt;
         addr_ff <= nxt_addr;
         data_ff <= nxt_data;
         rdata_ff <= nxt_rdata;
         fstat_ff <= nxt_fstat;
         busy_ff <= nxt_busy;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         dq_s1_ff <= flash_dq_in;
         dq_s2_ff <= dq_s1_ff;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = 1'b0;
   assign flash_ce_n = pins_ff.ce_n;
   assign flash_oe_n = pins_ff.oe_n;
   assign flash_we_n = pins_ff.we_n;
   assign flash_addr = pins_ff.addr;
   assign flash_dq_out = dq_ff;
   assign flash_dq_oe = dq_oe_ff;

   // ==========================================
   // checks
   chk_we_needs_ce: assert property (@(posedge core_clk) disable iff (rst)
      !flash_we_n |-> !flash_ce_n && flash_dq_oe) else $error("we low without ce");
   chk_no_oe_on_write: assert property (@(posedge core_clk) disable iff (rst)
      !flash_we_n |-> flash_oe_n) else $error("oe and we low together");
   chk_erase_cmds: assert property (@(posedge core_clk) disable iff (rst)
      (!flash_we_n && op_ff == OP_ERASE) |-> flash_dq_out[7:0] == 8'h20
      || flash_dq_out[7:0] == 8'hd0) else $error("bad erase code");
   chk_clear_code: assert property (@(posedge core_clk) disable iff (rst)
      (!flash_we_n && op_ff == OP_CLEAR) |-> flash_dq_out[7:0] == 8'h50)
      else $error("bad clear code");
   chk_pready_pulse: assert property (@(posedge core_clk) disable iff (rst)
      pready |=> !pready) else $error("pready held");
   chk_done_deselect: assert property (@(posedge core_clk) disable iff (rst)
      state_ff == ST_DONE |=> flash_ce_n && flash_oe_n) else $error("no deselect");
endmodule : fpes_host

// ===== fpes_flash_model.sv
// behavioural flash device facing the host controller
`timescale 1ns/1ps
module fpes_flash_model (
   input wire logic core_clk,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [17:0] addr,
   input wire logic [15:0] dq_out,
   input wire logic dq_oe,
   input wire logic vpp_ok,
   input wire logic fail_inj,
   output logic [15:0] dq_in
);
   // ========
   // state
   logic [15:0] mem [logic [17:0]]; // unwritten cells read erased
   logic [5:3] sr = 3'b000; // sticky error bits
   logic rd_st = 1'b0; // read path shows status
   logic susp = 1'b0; // kept with chip deselected
   logic ers = 1'b0;
   logic tgl = 1'b0;
   logic [1:0] arm = 2'd0; // 1 program data next, 2 confirm next
   logic [5:0] blk = 6'h00;
   logic [7:0] c, st;
   int busy = 0;
   function automatic logic [15:0] rd(input logic [17:0] a);
      rd = mem.exists(a) ? mem[a] : 16'hffff;
   endfunction : rd
   // ========
   // command writes, taken on the rising write strobe
   always @(posedge we_n) if (!ce_n && dq_oe) begin
      c = dq_out[7:0];
      if (arm == 2'd1) begin // program data write
         arm = 2'd0;
         rd_st = 1'b1;
         if (!vpp_ok) sr[3] = 1'b1;
         else begin // only clears bits
            busy = 100;
            ers = 1'b0;
            if (fail_inj) sr[4] = 1'b1; // cell left as it was
            else mem[addr] = rd(addr) & dq_out;
         end
      end else if (arm == 2'd2) begin
         arm = 2'd0;
         rd_st = 1'b1;
         if (c != 8'hd0) sr[5:4] = 2'b11;
         else if (!vpp_ok || sr[3]) sr = 3'b101 | sr;
         else begin // block latched at confirm
            busy = 400;
            ers = 1'b1;
            blk = addr[17:12];
         end
      end else if (busy > 0 && !susp) begin // others ignored
         if (c == 8'h70) rd_st = 1'b1;
         else if (c == 8'hb0 && ers) begin
            susp = 1'b1;
            rd_st = 1'b1;
         end
      end else if (susp) begin
         if (c == 8'hff) rd_st = 1'b0;
         else if (c == 8'h70) rd_st = 1'b1;
         else if (c == 8'hd0) begin
            susp = 1'b0;
            rd_st = 1'b1;
         end
      end else case (c)
         8'hff: rd_st = 1'b0;
         8'h40, 8'h10: arm = 2'd1;
         8'h20: arm = 2'd2;
         8'h50: sr = 3'b000;
         8'h70: rd_st = 1'b1;
         default: ; // resume without suspend does nothing
      endcase
   end
   // ========
   // internal timing; erase lands when the count runs out
   always @(posedge core_clk) begin
      tgl <= ~tgl;
      if (busy > 0 && !susp) begin
         busy--;
         if (busy == 0 && ers && fail_inj) sr[5] = 1'b1; // block left unerased
         else if (busy == 0 && ers)
            foreach (mem[k]) if (k[17:12] == blk) mem[k] = 16'hffff;
      end
   end
   // released bus toggles so a stale value never passes
   assign st = {busy == 0 || susp, susp, sr, 3'b000};
   assign dq_in = (!ce_n && !oe_n) ? (rd_st ? {8'h00, st} : rd(addr)) : {16{tgl}};
endmodule : fpes_flash_model

// ===== test_flash_program_erase_sequencer.sv
// testbench: host controller driving the behavioural flash
`timescale 1ns/1ps
module test_flash_program_erase_sequencer
   import fpes_pkg::*;
;
   // ========
   // signals
   logic core_clk;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic vpp_ok = 1'b1;
   logic fail_inj = 1'b0; // makes the model's program and erase fail
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   logic pready, pslverr, ce_n, oe_n, we_n, dq_oe;
   logic [17:0] faddr;
   logic [15:0] dq_out, dq_in;
   int fail_count = 0;
   int n_tests = 0;
   typedef struct {fpes_op_type op; logic [17:0] a; logic [15:0] d; logic [7:0] rg; logic [15:0] x;}
      fpes_row_type;
   fpes_row_type rows[14] = '{
      '{OP_CLEAR, 18'h0, 16'h0, 8'hff, 16'h0},
      '{OP_PROGRAM, 18'h10, 16'h1234, REG_FSTAT, 16'h00},
      '{OP_POLL, 18'h0, 16'h0, REG_FSTAT, 16'h80},
      '{OP_READ_ARRAY, 18'h10, 16'h0, REG_RDATA, 16'h1234},
      '{OP_PROGRAM, 18'h10, 16'hff00, REG_FSTAT, 16'h00},
      '{OP_READ_ARRAY, 18'h10, 16'h0, REG_RDATA, 16'h0000},
      '{OP_POLL, 18'h0, 16'h0, REG_FSTAT, 16'h80},
      '{OP_READ_ARRAY, 18'h10, 16'h0, REG_RDATA, 16'h1200},
      '{OP_ERASE, 18'h10, 16'h0, REG_FSTAT, 16'h00},
      '{OP_SUSPEND, 18'h0, 16'h0, REG_FSTAT, 16'hc0},
      '{OP_READ_ARRAY, 18'h01010, 16'h0, REG_RDATA, 16'hffff},
      '{OP_RESUME, 18'h0, 16'h0, REG_FSTAT, 16'h00},
      '{OP_POLL, 18'h0, 16'h0, REG_FSTAT, 16'h80},
      '{OP_READ_ARRAY, 18'h10, 16'h0, REG_RDATA, 16'hffff}};
   // ========
   // design and far side
   fpes_host u_fpes_host (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
      .flash_addr(faddr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in));
   fpes_flash_model u_fpes_flash_model (.core_clk(core_clk), .ce_n(ce_n), .we_n(we_n),
      .oe_n(oe_n), .addr(faddr), .dq_out(dq_out), .dq_oe(dq_oe), .vpp_ok(vpp_ok),
      .fail_inj(fail_inj), .dq_in(dq_in));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // ========
   // tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // apb master: holds the request until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      // no cycle count assumed: only the watchdog ends a stalled wait
      while (pready !== 1'b1) begin
         @(posedge core_clk);
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb
   // one flash operation, waiting out the busy flag
   task automatic run_op(input fpes_op_type op, input logic [17:0] a, input logic [15:0] d);
      logic [31:0] q;
      apb(1'b1, REG_ADDR, {14'h0, a}, q);
      apb(1'b1, REG_DATA, {16'h0, d}, q);
      apb(1'b1, REG_CTRL, {29'h0, op}, q);
      q = 32'h1;
      while (q[0] !== 1'b0) begin
         apb(1'b0, REG_STAT, 32'h0, q);
      end
   endtask : run_op
   // polls the flash until its ready bit shows; a hang is left to the watchdog
   task automatic poll_ready();
      logic [31:0] q;
      q = 32'h0;
      while (q[7] !== 1'b1) begin
         run_op(OP_POLL, 18'h0, 16'h0);
         apb(1'b0, REG_FSTAT, 32'h0, q);
      end
   endtask : poll_ready
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   // ========
   // sequence
   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      check({27'h0, pslverr, ce_n, oe_n, we_n, dq_oe}, 32'he);
      @(posedge core_clk);
      apb(1'b0, 8'h3c, 32'h0, r);
      check(r, 32'h0);
      foreach (rows[i]) begin
         run_op(rows[i].op, rows[i].a, rows[i].d);
         for (int k = 0; rows[i].op == OP_POLL && k < 40; k++) begin
            apb(1'b0, REG_FSTAT, 32'h0, r);
            if (r[7] === 1'b1) break;
            run_op(OP_POLL, 18'h0, 16'h0);
         end
         if (rows[i].rg != 8'hff) begin
            apb(1'b0, rows[i].rg, 32'h0, r);
            check(r, {16'h0, rows[i].x});
         end
         $display("row %0d done", i);
      end
      vpp_ok <= 1'b0;
      run_op(OP_PROGRAM, 18'h20, 16'h0);
      apb(1'b0, REG_FSTAT, 32'h0, r);
      check(r, 32'h88);
      run_op(OP_ERASE, 18'h20, 16'h0);
      apb(1'b0, REG_FSTAT, 32'h0, r);
      check(r, 32'ha8);
      vpp_ok <= 1'b1;
      run_op(OP_ERASE, 18'h20, 16'h0);
      apb(1'b0, REG_FSTAT, 32'h0, r);
      check(r, 32'ha8);
      run_op(OP_CLEAR, 18'h0, 16'h0);
      run_op(OP_POLL, 18'h0, 16'h0);
      apb(1'b0, REG_FSTAT, 32'h0, r);
      check(r, 32'h80);
      $display("supply test done");
      fail_inj <= 1'b1;
      run_op(OP_PROGRAM, 18'h30, 16'h0);
      poll_ready();
      apb(1'b0, REG_FSTAT, 32'h0, r);
      check(r, 32'h90);
      run_op(OP_ERASE, 18'h30, 16'h0);
      poll_ready();
      apb(1'b0, REG_FSTAT, 32'h0, r);
      check(r, 32'hb0);
      fail_inj <= 1'b0;
      $display("failure test done");
      // reset in the middle of a command write
      apb(1'b1, REG_CTRL, {29'h0, OP_POLL}, r);
      repeat (3) @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      check({27'h0, pslverr, ce_n, oe_n, we_n, dq_oe}, 32'he);
      rst <= 1'b0;
      @(posedge core_clk);
      apb(1'b0, REG_STAT, 32'h0, r);
      check(r, 32'h0);
      apb(1'b0, REG_FSTAT, 32'h0, r);
      check(r, 32'h0);
      $display("reset test done");
      give_verdict();
   end
   // watchdog well beyond the expected few thousand cycles
   initial begin
      repeat (30000) @(posedge core_clk);
      fail_count++;
      give_verdict();
   end
endmodule : test_flash_program_erase_sequencer
